//--- sim/cmd_dispatch_props.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_dispatch_props
  import cmd_dispatch_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        hw_reset_active,
  input wire logic        fis_rx_valid,
  input wire logic [7:0]  fis_rx_type,
  input wire logic        fis_rx_cmd,
  input wire logic        fis_rx_srst,
  input wire logic        ncq_outstanding,
  input wire logic [2:0]  cmd_protocol,
  input wire logic        cmd_known,
  input wire logic        tx_done,
  input wire logic        d2h_reg_req,
  input wire logic [7:0]  sig_error,
  input wire logic [7:0]  sig_status,
  input wire logic        dma_setup_seen,
  input wire logic [3:0]  protocol_go,
  input wire logic [10:0] cur_state
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire reg_fis = fis_rx_type == FIS_REG_H2D;
  wire in_fis = cur_state == fis_check_state;
  hw_wait_a: assert property (hw_reset_active |=> cur_state == hw_reset_wait_state)
    else $error("hw reset not taken");
  diag_go_a: assert property (cur_state == hw_reset_wait_state && !hw_reset_active
    |=> cur_state == power_up_diag_state) else $error("diag not started");
  tx_idle_a: assert property (cur_state inside {good_status_state, bad_status_state}
    && tx_done && !hw_reset_active && !fis_rx_valid |=> cur_state == idle_state)
    else $error("no idle");
  good_err_a: assert property (cur_state == good_status_state |-> sig_error == ERR_GOOD)
    else $error("good error field");
  bad_err_a: assert property (cur_state == bad_status_state |-> sig_error != 8'h01
    && sig_error < 8'h80) else $error("bad error field");
  sts_bits_a: assert property (d2h_reg_req |-> (sig_status & 8'h8F) == 8'h00)
    else $error("status bits");
  soft_reset_a: assert property (fis_rx_valid && reg_fis && !fis_rx_cmd && fis_rx_srst
    && cur_state != hw_reset_wait_state && !hw_reset_active
    |-> ##[1:2] cur_state == soft_reset_asserted_state) else $error("no soft reset");
  no_reply_a: assert property (in_fis && reg_fis && !fis_rx_cmd && !fis_rx_srst
    && !hw_reset_active |=> cur_state == idle_state && !d2h_reg_req) else $error("reply sent");
  dma_seen_a: assert property (in_fis && fis_rx_type == FIS_DMA_SETUP
    && !hw_reset_active |=> dma_setup_seen && cur_state == idle_state) else $error("dma setup");
  go_code_a: assert property (cur_state == command_check_state && !ncq_outstanding
    && cmd_known && !hw_reset_active && !fis_rx_valid |=> protocol_go ==
    ($past(cmd_protocol) < 3'h4 ? {1'b0, $past(cmd_protocol)} + 4'h1 : GO_NO_CMD))
    else $error("dispatch");
  cover property (cur_state == good_status_state);
  cover property (cur_state == bad_status_state);
  cover property (cur_state == soft_reset_asserted_state);
  cover property (cur_state == host_alert_state);
endmodule
bind cmd_dispatch cmd_dispatch_props u_cmd_dispatch_props (.pclk, .presetn,
  .hw_reset_active, .fis_rx_valid, .fis_rx_type, .fis_rx_cmd, .fis_rx_srst,
  .ncq_outstanding, .cmd_protocol, .cmd_known, .tx_done, .d2h_reg_req, .sig_error,
  .sig_status, .dma_setup_seen, .protocol_go, .cur_state);
`default_nettype wire

//--- sim/cmd_dispatch_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_dispatch_tb
  import cmd_dispatch_pkg::*;
;
  logic pclk = 1'b0, presetn, psel, penable, pwrite, hw_reset_active, soft_reset_done;
  logic fis_rx_valid, fis_rx_cmd, fis_rx_srst, fis_rx_error, ncq_outstanding, cmd_known;
  logic release_ready, wr_data_ready, rd_data_ready, ncq_done_ok, ncq_failed, tx_done;
  logic protocol_done, slow, d2h_reg_req, pready, pslverr, sdb_service_req;
  logic host_alert_req, dma_setup_seen, soft_reset_active, e;
  logic [7:0] paddr, fis_rx_type, sig_count, sig_lba_low, sig_lba_mid, sig_lba_high;
  logic [7:0] sig_error, sig_status;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] cmd_protocol;
  logic [3:0] protocol_go, last_go, seen;
  logic [10:0] cur_state;
  int n_mismatch = 0;
  int checks = 0;
  logic clr_q = 1'b0;
  always #25 pclk = ~pclk;
  cmd_dispatch u_cmd_dispatch (.*);
  host_transport_model u_host_transport_model (.*);
  always @(posedge pclk) begin
    if (clr_q) begin
      seen <= 4'h0;
      last_go <= 4'h0;
    end else begin
      if (protocol_go !== 4'h0)
        last_go <= protocol_go;
      seen <= seen | {host_alert_req, sdb_service_req, dma_setup_seen, d2h_reg_req};
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task clr;
    @(posedge pclk);
    clr_q <= 1'b1;
    @(posedge pclk);
    clr_q <= 1'b0;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task fis(input logic [7:0] t, input logic c, input logic s);
    @(posedge pclk);
    fis_rx_valid <= 1'b1;
    fis_rx_type <= t;
    fis_rx_cmd <= c;
    fis_rx_srst <= s;
    @(posedge pclk);
    fis_rx_valid <= 1'b0;
    cyc(4);
  endtask
  task fin;
    @(posedge pclk);
    protocol_done <= 1'b1;
    @(posedge pclk);
    protocol_done <= 1'b0;
    cyc(2);
  endtask
  task boot(input logic ok, input logic [7:0] er);
    @(posedge pclk);
    hw_reset_active <= 1'b1;
    slow <= !ok;
    cyc(2);
    chk(cur_state, 32'h1);
    apb(1'b1, REG_CTRL, {16'h0000, er, 4'hF, 2'b01, ok, 1'b0});
    clr;
    hw_reset_active <= 1'b0;
    cyc(3);
    chk(cur_state, ok ? 32'h4 : 32'h8);
    chk({sig_lba_high, sig_lba_mid, sig_lba_low, sig_count}, 32'h0000_0101);
    chk(sig_error, ok ? 8'h01 : (er == 8'h01 || er > 8'h7F) ? 8'h00 : er);
    chk(sig_status, {1'b0, er[2:0], 4'h0});
    cyc(14);
    chk(cur_state, 32'h10);
  endtask
  task idl(input logic [3:0] lv, input logic [3:0] ex);
    clr;
    {release_ready, wr_data_ready, rd_data_ready, ncq_done_ok} <= lv;
    @(posedge pclk);
    {release_ready, wr_data_ready, rd_data_ready, ncq_done_ok} <= 4'h0;
    cyc(3);
    chk(last_go, ex);
    fin;
  endtask
  task conclude;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    cyc(5000);
    n_mismatch++;
    conclude;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, soft_reset_done, fis_rx_valid} = '0;
    {fis_rx_type, fis_rx_cmd, fis_rx_srst, fis_rx_error, ncq_outstanding} = '0;
    {cmd_protocol, release_ready, wr_data_ready, rd_data_ready, ncq_done_ok} = '0;
    {ncq_failed, protocol_done, slow} = '0;
    hw_reset_active = 1'b1;
    cmd_known = 1'b1;
    cyc(10);
    presetn <= 1'b1;
    boot(1'b1, 8'h35);
    boot(1'b0, 8'h05);
    boot(1'b0, 8'h01);
    boot(1'b0, 8'h80);
    $display("boot tests done");
    apb(1'b0, REG_STATE, 32'h0);
    chk(r[10:0], 32'h10);
    apb(1'b1, 8'h10, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, REG_STATE, 32'h0);
    chk(e, 1'b1);
    $display("register tests done");
    for (int p = 0; p < 4; p++) begin
      cmd_protocol <= p[2:0];
      clr;
      fis(FIS_REG_H2D, 1'b1, 1'b0);
      chk(last_go, p[3:0] + 4'h1);
      fin;
      chk(cur_state, 32'h10);
    end
    ncq_outstanding <= 1'b1;
    clr;
    fis(FIS_REG_H2D, 1'b1, 1'b0);
    chk(last_go, GO_NO_CMD);
    fin;
    ncq_outstanding <= 1'b0;
    clr;
    fis(FIS_REG_H2D, 1'b0, 1'b0);
    chk(seen[0], 1'b0);
    fis(FIS_DMA_SETUP, 1'b0, 1'b0);
    chk(seen[1], 1'b1);
    fis(8'h39, 1'b0, 1'b0);
    chk(cur_state, 32'h10);
    $display("fis tests done");
    idl(4'b0101, GO_SEND_STS);
    idl(4'b0011, GO_SEND_STS);
    idl(4'b0100, GO_WR_SETUP);
    idl(4'b0010, GO_RD_SETUP);
    $display("idle tests done");
    clr;
    release_ready <= 1'b1;
    cyc(3);
    release_ready <= 1'b0;
    chk(seen[2], 1'b1);
    chk(cur_state, 32'h100);
    hw_reset_active <= 1'b1;
    cyc(2);
    chk(cur_state, 32'h1);
    boot(1'b1, 8'h35);
    clr;
    apb(1'b1, REG_CTRL, 32'h0000_35FF);
    cyc(4);
    chk(seen[3], 1'b1);
    fis(FIS_REG_H2D, 1'b0, 1'b1);
    chk(cur_state, 32'h80);
    chk(soft_reset_active, 1'b1);
    soft_reset_done <= 1'b1;
    cyc(2);
    soft_reset_done <= 1'b0;
    chk(cur_state, 32'h10);
    apb(1'b0, REG_STATE, 32'h0);
    chk(r[12:11], 2'b11);
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_EVENT, 32'h1);
    fis(FIS_REG_H2D, 1'b1, 1'b0);
    fin;
    apb(1'b0, REG_STATE, 32'h0);
    chk(r[12:11], 2'b00);
    $display("reset tests done");
    conclude;
  end
endmodule
`default_nettype wire

//--- sim/host_transport_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_transport_model (
  input wire logic  pclk,
  input wire logic  d2h_reg_req,
  input wire logic  sdb_service_req,
  input wire logic  host_alert_req,
  input wire logic  slow,
  output var logic  tx_done
);
  logic [3:0] cnt_q;
  logic       pend_q;
  // register frame confirmed after a short or long delay, other frames two cycles after their request
  always_ff @(posedge pclk) begin
    cnt_q <= (d2h_reg_req && !tx_done) ? cnt_q + 4'h1 : 4'h0;
    pend_q <= sdb_service_req || host_alert_req;
    tx_done <= (d2h_reg_req && !tx_done && cnt_q == (slow ? 4'h8 : 4'h0)) || pend_q;
  end
endmodule
`default_nettype wire

//--- src/cmd_dispatch.sv
// Notes on behaviour
// - link reset aborts protocol, restarts reset sequence
// - soft reset register FIS restarts soft reset
// - hardware reset runs in any state
// - wait for reset negation, then diagnostics
// - diagnostics pass or fail picks status state
// - ATA good signature 01,01,00,00, error 01
// - packet signature 01,01,14,EB, error 01, status 00
// - zoned signature 01,01,CD,AB, error 01
// - only status bits 6:4 may be nonzero
// - bad status: same signature, error 00 or 02-7F
// - wait transmit confirm, then go idle
// - write data ready, quiet: write setup
// - read data ready, quiet: read setup
// - no aggregation: status send wins
// - notification conditions met: host alert state
// - DMA setup or unknown FIS: back to idle
// - register FIS C=0 SRST=1: soft reset state
// - register FIS C=0 SRST=0: idle, no reply
// - register FIS C=1: command checking
// - command check clears notification outstanding flag
// - tell transport of DMA setup receipt
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module cmd_dispatch
  import cmd_dispatch_pkg::*;
#(
  parameter bit         STATUS_AGGREGATION = 1'b0,
  parameter logic [1:0] DEVICE_TYPE        = DEV_ATA
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hw_reset_active,
  input  wire logic        soft_reset_done,
  input  wire logic        fis_rx_valid,
  input  wire logic [7:0]  fis_rx_type,
  input  wire logic        fis_rx_cmd,
  input  wire logic        fis_rx_srst,
  input  wire logic        fis_rx_error,
  input  wire logic        ncq_outstanding,
  input  wire logic [2:0]  cmd_protocol,
  input  wire logic        cmd_known,
  input  wire logic        release_ready,
  input  wire logic        wr_data_ready,
  input  wire logic        rd_data_ready,
  input  wire logic        ncq_done_ok,
  input  wire logic        ncq_failed,
  input  wire logic        tx_done,
  input  wire logic        protocol_done,
  output logic             d2h_reg_req,
  output logic      [7:0]  sig_count,
  output logic      [7:0]  sig_lba_low,
  output logic      [7:0]  sig_lba_mid,
  output logic      [7:0]  sig_lba_high,
  output logic      [7:0]  sig_error,
  output logic      [7:0]  sig_status,
  output logic             sdb_service_req,
  output logic             host_alert_req,
  output logic             dma_setup_seen,
  output logic             soft_reset_active,
  output logic      [3:0]  protocol_go,
  output logic      [10:0] cur_state
);

  typedef struct packed {
    state_t      st;
    logic [31:0] ctrl;
    logic        alert_pend;
    logic        host_alert_outstanding;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        d2h_req;
    logic [7:0]  cnt;
    logic [7:0]  lo;
    logic [7:0]  mid;
    logic [7:0]  hi;
    logic [7:0]  err;
    logic [7:0]  sts;
    logic        serv;
    logic        alert;
    logic        dmas;
    logic        srst;
    logic [3:0]  go;
  } regs_t;

  regs_t q;
  regs_t d;

  function automatic logic [7:0] bad_error(input logic [7:0] v);
    if (v == ERR_GOOD || v[7])
      bad_error = ERR_BAD_DFLT;
    else
      bad_error = v;
  endfunction

  function automatic logic [7:0] status_of(input logic [7:0] v, input logic [1:0] t);
    if (t == DEV_PACKET)
      status_of = 8'h00;
    else
      status_of = v & STATUS_MASK;
  endfunction

  // register FIS with command flag clear and soft reset flag set
  function automatic logic is_srst_fis(input logic [7:0] t, input logic c, input logic s);
    is_srst_fis = (t == FIS_REG_H2D) && !c && s;
  endfunction

  logic acc;
  logic quiet;

  always_comb begin
    d       = q;
    acc     = psel && penable && !q.ready;
    quiet   = !fis_rx_valid && !fis_rx_error;
    d.ready  = 1'b0;
    d.slverr = 1'b0;
    d.serv   = 1'b0;
    d.alert  = 1'b0;
    d.dmas   = 1'b0;
    d.go     = GO_NONE;

    if (q.ctrl[CTRL_ALERT_EV])
      d.alert_pend = 1'b1;

    // APB slave, one wait state
    if (acc) begin
      d.ready = 1'b1;
      d.rdata = 32'h0000_0000;
      case (paddr)
        REG_CTRL: begin
          if (pwrite)
            d.ctrl = pwdata;
          else
            d.rdata = q.ctrl;
        end
        REG_STATE: begin
          if (pwrite)
            d.slverr = 1'b1;
          else
            d.rdata = {19'h0, q.alert_pend, q.host_alert_outstanding, q.st};
        end
        REG_SIG: begin
          if (pwrite)
            d.slverr = 1'b1;
          else
            d.rdata = {q.hi, q.mid, q.lo, q.cnt};
        end
        REG_EVENT: begin
          if (pwrite && pwdata[0])
            d.alert_pend = 1'b0;
          else if (!pwrite)
            d.rdata = {31'h0, q.alert_pend};
        end
        default: d.slverr = 1'b1;
      endcase
    end
    if (q.ctrl[CTRL_ALERT_EV])
      d.alert_pend = 1'b1;

    case (q.st)
      hw_reset_wait_state: begin
        if (!hw_reset_active)
          d.st = power_up_diag_state;
      end
      power_up_diag_state: begin
        if (q.ctrl[CTRL_DIAG_DONE]) begin
          d.cnt = SIG_COUNT;
          d.lo  = SIG_LBA_LOW;
          case (DEVICE_TYPE)
            DEV_PACKET: begin
              d.mid = SIG_PKT_MID;
              d.hi  = SIG_PKT_HIGH;
            end
            DEV_ZONED: begin
              d.mid = SIG_ZON_MID;
              d.hi  = SIG_ZON_HIGH;
            end
            default: begin
              d.mid = SIG_ATA_MID;
              d.hi  = SIG_ATA_HIGH;
            end
          endcase
          d.sts     = status_of(q.ctrl[CTRL_STS_LSB +: 8], DEVICE_TYPE);
          d.d2h_req = 1'b1;
          if (q.ctrl[CTRL_DIAG_OK]) begin
            d.err = ERR_GOOD;
            d.st  = good_status_state;
          end else begin
            d.err = bad_error(q.ctrl[CTRL_ERR_LSB +: 8]);
            d.st  = bad_status_state;
          end
        end
      end
      good_status_state, bad_status_state: begin
        if (tx_done) begin
          d.d2h_req = 1'b0;
          d.st      = idle_state;
        end
      end
      idle_state: begin
        if (fis_rx_valid)
          d.st = fis_check_state;
        else if (release_ready) begin
          d.serv = 1'b1;
          d.st   = service_request_state;
        end else if (ncq_failed) begin
          d.go = GO_NCQ_ERROR;
          d.st = protocol_state;
        end else if (quiet && ncq_done_ok && !STATUS_AGGREGATION) begin
          d.go = GO_SEND_STS;
          d.st = protocol_state;
        end else if (quiet && wr_data_ready) begin
          d.go = GO_WR_SETUP;
          d.st = protocol_state;
        end else if (quiet && rd_data_ready) begin
          d.go = GO_RD_SETUP;
          d.st = protocol_state;
        end else if (quiet && ncq_done_ok) begin
          d.go = GO_SEND_STS;
          d.st = protocol_state;
        end else if (q.ctrl[CTRL_AN_EN] && q.alert_pend && !q.host_alert_outstanding) begin
          d.alert = 1'b1;
          d.host_alert_outstanding = 1'b1;
          d.alert_pend = q.ctrl[CTRL_ALERT_EV];
          d.st = host_alert_state;
        end
      end
      fis_check_state: begin
        if (is_srst_fis(fis_rx_type, fis_rx_cmd, fis_rx_srst))
          d.st = soft_reset_asserted_state;
        else if (fis_rx_type == FIS_REG_H2D && !fis_rx_cmd)
          d.st = idle_state;
        else if (fis_rx_type == FIS_REG_H2D)
          d.st = command_check_state;
        else if (fis_rx_type == FIS_DMA_SETUP) begin
          d.dmas = 1'b1;
          d.st   = idle_state;
        end else
          d.st = idle_state;
      end
      command_check_state: begin
        d.host_alert_outstanding = 1'b0;
        d.st = protocol_state;
        if (ncq_outstanding)
          d.go = GO_NO_CMD;
        else if (!cmd_known)
          d.go = GO_NO_CMD;
        else begin
          case (cmd_protocol)
            PROTO_NONDATA: d.go = GO_NONDATA;
            PROTO_PIO_IN:  d.go = GO_PIO_IN;
            PROTO_PIO_OUT: d.go = GO_PIO_OUT;
            PROTO_DMA_IN:  d.go = GO_DMA_IN;
            default:       d.go = GO_NO_CMD;
          endcase
        end
      end
      soft_reset_asserted_state: begin
        d.srst = 1'b1;
        if (soft_reset_done) begin
          d.srst = 1'b0;
          d.st   = idle_state;
        end
      end
      service_request_state, host_alert_state: begin
        if (tx_done)
          d.st = idle_state;
      end
      protocol_state: begin
        if (protocol_done)
          d.st = idle_state;
      end
      default: d.st = hw_reset_wait_state;
    endcase

    // soft reset register FIS mid-protocol restarts soft reset
    if (q.st != fis_check_state && q.st != idle_state && q.st != hw_reset_wait_state
        && fis_rx_valid && is_srst_fis(fis_rx_type, fis_rx_cmd, fis_rx_srst)) begin
      d.go   = GO_NONE;
      d.srst = 1'b0;
      d.st   = soft_reset_asserted_state;
    end

    // link reset overrides every state
    if (hw_reset_active) begin
      d.st      = hw_reset_wait_state;
      d.d2h_req = 1'b0;
      d.srst    = 1'b0;
      d.go      = GO_NONE;
      d.serv    = 1'b0;
      d.alert   = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q      <= '0;
      q.st   <= hw_reset_wait_state;
      q.ctrl <= CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  assign prdata            = q.rdata;
  assign pready            = q.ready;
  assign pslverr           = q.slverr;
  assign d2h_reg_req       = q.d2h_req;
  assign sig_count         = q.cnt;
  assign sig_lba_low       = q.lo;
  assign sig_lba_mid       = q.mid;
  assign sig_lba_high      = q.hi;
  assign sig_error         = q.err;
  assign sig_status        = q.sts;
  assign sdb_service_req   = q.serv;
  assign host_alert_req    = q.alert;
  assign dma_setup_seen    = q.dmas;
  assign soft_reset_active = q.srst;
  assign protocol_go       = q.go;
  assign cur_state         = q.st;

endmodule

`default_nettype wire

//--- src/cmd_dispatch_pkg.sv
package cmd_dispatch_pkg;

  // device type selection
  localparam logic [1:0] DEV_ATA       = 2'h0;
  localparam logic [1:0] DEV_PACKET    = 2'h1;
  localparam logic [1:0] DEV_ZONED     = 2'h2;

  // FIS type codes
  localparam logic [7:0] FIS_REG_H2D   = 8'h27;
  localparam logic [7:0] FIS_DMA_SETUP = 8'h41;

  // signature fields
  localparam logic [7:0] SIG_COUNT     = 8'h01;
  localparam logic [7:0] SIG_LBA_LOW   = 8'h01;
  localparam logic [7:0] SIG_ATA_MID   = 8'h00;
  localparam logic [7:0] SIG_ATA_HIGH  = 8'h00;
  localparam logic [7:0] SIG_PKT_MID   = 8'h14;
  localparam logic [7:0] SIG_PKT_HIGH  = 8'hEB;
  localparam logic [7:0] SIG_ZON_MID   = 8'hCD;
  localparam logic [7:0] SIG_ZON_HIGH  = 8'hAB;
  localparam logic [7:0] ERR_GOOD      = 8'h01;
  localparam logic [7:0] ERR_BAD_DFLT  = 8'h00;
  localparam logic [7:0] STATUS_MASK   = 8'h70;

  // command protocol classes from the decoder
  localparam logic [2:0] PROTO_NONDATA = 3'h0;
  localparam logic [2:0] PROTO_PIO_IN  = 3'h1;
  localparam logic [2:0] PROTO_PIO_OUT = 3'h2;
  localparam logic [2:0] PROTO_DMA_IN  = 3'h3;

  // APB register map
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATE     = 8'h04;
  localparam logic [7:0] REG_SIG       = 8'h08;
  localparam logic [7:0] REG_EVENT     = 8'h0C;

  // control register fields
  localparam int CTRL_AN_EN    = 0;
  localparam int CTRL_DIAG_OK  = 1;
  localparam int CTRL_DIAG_DONE = 2;
  localparam int CTRL_ALERT_EV = 3;
  localparam int CTRL_STS_LSB  = 4;
  localparam int CTRL_ERR_LSB  = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // dispatch targets
  localparam logic [3:0] GO_NONE       = 4'h0;
  localparam logic [3:0] GO_NONDATA    = 4'h1;
  localparam logic [3:0] GO_PIO_IN     = 4'h2;
  localparam logic [3:0] GO_PIO_OUT    = 4'h3;
  localparam logic [3:0] GO_DMA_IN     = 4'h4;
  localparam logic [3:0] GO_NO_CMD     = 4'h5;
  localparam logic [3:0] GO_WR_SETUP   = 4'h6;
  localparam logic [3:0] GO_RD_SETUP   = 4'h7;
  localparam logic [3:0] GO_SEND_STS   = 4'h8;
  localparam logic [3:0] GO_NCQ_ERROR  = 4'h9;

  typedef enum logic [10:0] {
    hw_reset_wait_state       = 11'h001,
    power_up_diag_state       = 11'h002,
    good_status_state         = 11'h004,
    bad_status_state          = 11'h008,
    idle_state                = 11'h010,
    fis_check_state           = 11'h020,
    command_check_state       = 11'h040,
    soft_reset_asserted_state = 11'h080,
    service_request_state     = 11'h100,
    host_alert_state          = 11'h200,
    protocol_state            = 11'h400
  } state_t;

endpackage
